// ===== verilog/fader_params.svh
`ifndef FADER_PARAMS_SVH
`define FADER_PARAMS_SVH
// Operation
// (RULE1) Route one of four stereo sources or the mono source to the selector.
// (RULE2) First volume stage spans +20 dB to -31 dB in 1 dB steps, shared.
// (RULE3) Second volume stage attenuates 0 dB to -55 dB in 1 dB steps.
// (RULE4) Host should keep combined gain between +20 dB and -66 dB.
// (RULE5) Loudness flat at +20 dB, deepens 32 dB down to -12 dB, then holds.
// (RULE6) Loudness is switched on or off by a bus-written setting.
// (RULE7) Bass setting selects -15 dB to +15 dB at 40 Hz.
// (RULE8) Treble setting selects -12 dB to +12 dB at 15 kHz in 1.5 dB steps.
// (RULE9) Bass and treble use 3 dB coarse steps plus 1.5 dB boost or cut.
// (RULE10) Tone off disconnects tone path; send pins drive, return pins receive.
// (RULE11) Four independent output attenuators, 55 dB in 1 dB steps plus mute step.
// (RULE12) Mute on general mute bit or any attenuator at its mute step.
// (RULE13) With zero-cross mode off, general mute changes act at once.
// (RULE14) With zero-cross mode on, each channel switches at its next crossing.
// (RULE15) Left and right crossing detectors act independently.
// (RULE16) Crossing wait ends after about 100 ms; switch then follows mute bit.
// (RULE17) Every new switch-word write restarts the crossing timeout; the code restarts it only with zero-cross mode on, else clears it.
// (RULE18) Mute pin low mutes every output at once, overriding bus mutes.
// (RULE19) Mute pin state is not stored; released pin leaves bus settings ruling.
// (RULE20) Host mutes the device before removing supply.
// (RULE21) Reset forces general mute and holds the serial receiver idle.
// (RULE22) Device answers address byte 1000 0000, then register select, then data.
// (RULE23) Register select auto-increments for each further data byte.
// (RULE24) Crossing event or timeout expiry, whichever comes first, moves the switch.

// Register indexes; byte address is four times the index
`define REG_VOLUME 4'h0
`define REG_ATT_FR 4'h1
`define REG_BASS 4'h5
`define REG_TREBLE 4'h6
`define REG_SWITCH 4'h7
`define REG_STATUS 4'h8
`define REG_LAST_RW 4'h7

// Field positions
`define VOL_LOUD_BIT 6
`define SW_TONE_BIT 3
`define SW_ZCM_BIT 6
`define SW_GMU_BIT 7
`define ST_BUSY_BIT 5

// Field limits
`define VOL1_MAX_CODE 6'h33
`define LOUD_MAX_DEPTH 6'h20
`define ATT_MAX_STEP 6'h37
`define SRC_MONO 3'h4
`define BASS_MID 5'h0A
`define BASS_MAX 5'h14
`define TREB_MID 5'h08
`define TREB_MAX 5'h10
`define DEV_ADDR 8'h80

// Reset values
`define RST_VOLUME 8'h00
`define RST_ATT 8'h00
`define RST_BASS 8'h0A
`define RST_TREBLE 8'h08
`define RST_SWITCH 8'h80

// Timing
`define ZC_TIMEOUT_MS 100
`define CORE_CLK_KHZ 40000
`endif

// ===== verilog/fader_pkg.sv
package fader_pkg;
    typedef enum logic [3:0] {
        PH_IDLE = 4'b0001,
        PH_ADDR = 4'b0010,
        PH_SUB = 4'b0100,
        PH_DATA = 4'b1000
    } i2cPhase_t;

    typedef struct packed {
        logic [3:0] coarse;
        logic boost;
        logic cut;
    } toneStep_t;
endpackage

// ===== verilog/audio_gain_mute_control.sv
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "fader_params.svh"
module audio_gain_mute_control #(
    parameter int unsigned ZcTimeoutCycles = `ZC_TIMEOUT_MS * `CORE_CLK_KHZ
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial bus pins
    input wire logic sclLine,
    input wire logic sdaLine,
    output logic sdaDrive,
    output logic sdaOe,
    // Mute pin and crossing comparators
    input wire logic muteN,
    input wire logic zeroCrossL,
    input wire logic zeroCrossR,
    // Analog path controls
    output logic [4:0] srcSelect,
    output logic [5:0] vol1Code,
    output logic [5:0] loudnessDepth,
    output logic [3:0][5:0] outAtten,
    output logic [3:0] outMute,
    output fader_pkg::toneStep_t bassStep,
    output fader_pkg::toneStep_t trebleStep,
    output logic toneEnable,
    output logic eqSendEnable,
    output logic eqReturnEnable
);
    import fader_pkg::*;

    localparam int unsigned TmrW = $clog2(ZcTimeoutCycles + 1);
    localparam logic [TmrW-1:0] TmrLoad = TmrW'(ZcTimeoutCycles);

    //--------------------------------------------------------------
    // State
    //--------------------------------------------------------------
    typedef struct packed {
        logic [7:0][7:0] regs;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [2:0] scl;
        logic [2:0] sda;
        logic [1:0] muteS;
        logic [2:0] zcL;
        logic [2:0] zcR;
        i2cPhase_t phase;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [2:0] sub;
        logic sdaOe;
        logic swL;
        logic swR;
        logic pendL;
        logic pendR;
        logic [TmrW-1:0] tmr;
        logic [4:0] srcSelect;
        logic [5:0] vol1Code;
        logic [5:0] loudnessDepth;
        logic [3:0][5:0] outAtten;
        logic [3:0] outMute;
        toneStep_t bassStep;
        toneStep_t trebleStep;
        logic toneEnable;
        logic eqPinsExternal;
    } state_t;

    state_t s_q;
    state_t s_d;

    //--------------------------------------------------------------
    // Tone step split
    //--------------------------------------------------------------
    // Odd half-steps reuse the 3 dB ladder one step toward zero plus a
    // 1.5 dB element, so only one fine element is ever switched in.
    function automatic toneStep_t toneMap(input logic [4:0] code, input logic [4:0] mid,
                                          input logic [4:0] maxCode);
        logic [4:0] k;
        logic signed [5:0] v;
        logic signed [5:0] c;
        toneStep_t r;
        k = (code > maxCode) ? maxCode : code;
        v = $signed({1'b0, k}) - $signed({1'b0, mid});
        r = '0;
        if (!v[0]) begin
            c = v >>> 1;
        end else if (v > 0) begin
            c = (v - 6'sd1) >>> 1;
            r.boost = 1'b1; // see (RULE9)
        end else begin
            c = (v + 6'sd1) >>> 1;
            r.cut = 1'b1; // see (RULE9)
        end
        r.coarse = c[3:0];
        return r;
    endfunction

    //--------------------------------------------------------------
    // Event decode
    //--------------------------------------------------------------
    logic sclRise, sclFall, busStart, busStop, byteDone, ackDone, addrDone, i2cDataDone;
    logic zcEdgeL, zcEdgeR, expire, apbAccess, apbMapped, apbWr, swWr, swGmu, swZcm, curGmu, hwMute;
    logic [3:0] apbIdx;
    logic [7:0] swData;

    assign sclRise = s_q.scl[1] & ~s_q.scl[2];
    assign sclFall = ~s_q.scl[1] & s_q.scl[2];
    assign busStart = s_q.scl[1] & s_q.scl[2] & ~s_q.sda[1] & s_q.sda[2];
    assign busStop = s_q.scl[1] & s_q.scl[2] & s_q.sda[1] & ~s_q.sda[2];
    assign byteDone = (s_q.phase != PH_IDLE) & sclFall & (s_q.bitCnt == 4'h8) & ~busStart & ~busStop;
    assign ackDone = (s_q.phase != PH_IDLE) & sclFall & (s_q.bitCnt == 4'h9) & ~busStart & ~busStop;
    assign addrDone = byteDone & (s_q.phase == PH_ADDR);
    assign i2cDataDone = byteDone & (s_q.phase == PH_DATA);
    assign zcEdgeL = s_q.zcL[1] ^ s_q.zcL[2]; // see (RULE24)
    assign zcEdgeR = s_q.zcR[1] ^ s_q.zcR[2]; // see (RULE24)
    assign expire = (s_q.tmr == TmrW'(1)); // see (RULE24)
    assign apbIdx = paddr[5:2];
    assign apbMapped = (paddr[7:6] == 2'b00) && (apbIdx <= `REG_STATUS);
    assign apbAccess = psel & penable & s_q.pready;
    assign apbWr = apbAccess & pwrite & apbMapped & (apbIdx <= `REG_LAST_RW);
    // APB wins when both buses hit the switch word in one cycle
    assign swWr = (apbWr && apbIdx == `REG_SWITCH) || (i2cDataDone && {1'b0, s_q.sub} == `REG_SWITCH);
    assign swData = (apbWr && apbIdx == `REG_SWITCH) ? pwdata[7:0] : s_q.shift;
    assign swGmu = swData[`SW_GMU_BIT];
    assign swZcm = swData[`SW_ZCM_BIT];
    assign curGmu = s_q.regs[`REG_SWITCH][`SW_GMU_BIT];
    assign hwMute = ~s_q.muteS[1];

    //--------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Synchronisers: index 0 is the first flop and feeds only index 1
        s_d.scl = {s_q.scl[1:0], sclLine};
        s_d.sda = {s_q.sda[1:0], sdaLine};
        s_d.muteS = {s_q.muteS[0], muteN};
        s_d.zcL = {s_q.zcL[1:0], zeroCrossL};
        s_d.zcR = {s_q.zcR[1:0], zeroCrossR};

        // Serial write receiver
        if (busStart) begin
            s_d.phase = PH_ADDR;
            s_d.bitCnt = 4'h0;
            s_d.sdaOe = 1'b0;
        end else if (busStop) begin
            s_d.phase = PH_IDLE;
            s_d.bitCnt = 4'h0;
            s_d.sdaOe = 1'b0;
        end else if (s_q.phase != PH_IDLE) begin
            if (sclRise && s_q.bitCnt < 4'h8) begin
                s_d.shift = {s_q.shift[6:0], s_q.sda[1]};
                s_d.bitCnt = s_q.bitCnt + 4'h1;
            end else if (byteDone) begin
                s_d.bitCnt = 4'h9;
                case (s_q.phase)
                    PH_ADDR: begin
                        // Read direction or foreign address: no acknowledge
                        if (s_q.shift == `DEV_ADDR) begin // see (RULE22)
                            s_d.sdaOe = 1'b1;
                            s_d.phase = PH_SUB;
                        end else begin
                            s_d.phase = PH_IDLE;
                        end
                    end
                    PH_SUB: begin
                        s_d.sub = s_q.shift[2:0]; // see (RULE22)
                        s_d.sdaOe = 1'b1;
                        s_d.phase = PH_DATA;
                    end
                    PH_DATA: begin
                        s_d.regs[s_q.sub] = s_q.shift;
                        s_d.sub = s_q.sub + 3'h1; // see (RULE23)
                        s_d.sdaOe = 1'b1;
                    end
                    default: begin
                        s_d.phase = PH_IDLE;
                    end
                endcase
            end else if (ackDone) begin
                s_d.sdaOe = 1'b0;
                s_d.bitCnt = 4'h0;
            end
        end

        // APB access: one wait state, data and error set on the wait cycle
        s_d.pready = psel & penable & ~s_q.pready;
        s_d.pslverr = 1'b0;
        if (psel && penable && !s_q.pready) begin
            s_d.pslverr = ~apbMapped | (pwrite & (apbIdx == `REG_STATUS));
            if (!pwrite && apbMapped) begin
                if (apbIdx == `REG_STATUS) begin
                    s_d.prdata = {26'h000_0000, s_q.phase != PH_IDLE, s_q.pendR, s_q.pendL,
                                  s_q.swR, s_q.swL, hwMute};
                end else begin
                    s_d.prdata = {24'h00_0000, s_q.regs[apbIdx[2:0]]};
                end
            end else begin
                s_d.prdata = 32'h0000_0000;
            end
        end
        if (apbWr) begin
            s_d.regs[apbIdx[2:0]] = pwdata[7:0];
        end

        // General mute switches
        if (s_q.tmr != '0) begin
            s_d.tmr = s_q.tmr - TmrW'(1);
        end
        if (swWr) begin
            if (!swZcm) begin
                s_d.swL = swGmu; // see (RULE13)
                s_d.swR = swGmu; // see (RULE13)
                s_d.pendL = 1'b0;
                s_d.pendR = 1'b0;
                s_d.tmr = '0;
            end else begin
                s_d.pendL = 1'b1; // see (RULE14)
                s_d.pendR = 1'b1; // see (RULE14)
                s_d.tmr = TmrLoad; // see (RULE17)
            end
        end else begin
            if (s_q.pendL && (zcEdgeL || expire)) begin // see (RULE15)
                s_d.swL = curGmu; // see (RULE16)
                s_d.pendL = 1'b0;
            end
            if (s_q.pendR && (zcEdgeR || expire)) begin // see (RULE15)
                s_d.swR = curGmu; // see (RULE16)
                s_d.pendR = 1'b0;
            end
            if (!s_d.pendL && !s_d.pendR) begin
                s_d.tmr = '0;
            end
        end

        // Analog path controls
        s_d.srcSelect = 5'h00;
        if (s_q.regs[`REG_SWITCH][2:0] >= `SRC_MONO) begin
            s_d.srcSelect[4] = 1'b1; // see (RULE1)
        end else begin
            s_d.srcSelect[s_q.regs[`REG_SWITCH][1:0]] = 1'b1; // see (RULE1)
        end
        // Code n gives 20 - n dB, shared by both channels
        s_d.vol1Code = (s_q.regs[`REG_VOLUME][5:0] > `VOL1_MAX_CODE) ?
                       `VOL1_MAX_CODE : s_q.regs[`REG_VOLUME][5:0]; // see (RULE2)
        if (!s_q.regs[`REG_VOLUME][`VOL_LOUD_BIT]) begin // see (RULE6)
            s_d.loudnessDepth = 6'h00;
        end else if (s_q.regs[`REG_VOLUME][5:0] >= `LOUD_MAX_DEPTH) begin
            s_d.loudnessDepth = `LOUD_MAX_DEPTH; // see (RULE5)
        end else begin
            s_d.loudnessDepth = s_q.regs[`REG_VOLUME][5:0]; // see (RULE5)
        end
        // Outputs 0..3: front right, front left, rear right, rear left
        for (int i = 0; i < 4; i++) begin
            s_d.outAtten[i] = s_q.regs[i + 1][5:0]; // see (RULE3) see (RULE11)
            s_d.outMute[i] = hwMute // see (RULE18) see (RULE19)
                           | (s_q.regs[i + 1][5:0] > `ATT_MAX_STEP) // see (RULE12)
                           | (i[0] ? s_q.swL : s_q.swR); // see (RULE12)
        end
        s_d.bassStep = toneMap(s_q.regs[`REG_BASS][4:0], `BASS_MID, `BASS_MAX); // see (RULE7)
        s_d.trebleStep = toneMap(s_q.regs[`REG_TREBLE][4:0], `TREB_MID, `TREB_MAX); // see (RULE8)
        s_d.toneEnable = s_q.regs[`REG_SWITCH][`SW_TONE_BIT];
        s_d.eqPinsExternal = ~s_q.regs[`REG_SWITCH][`SW_TONE_BIT]; // see (RULE10)

        // Synchronous reset: forced mute, receiver idle
        if (rst) begin
            s_d = '0;
            s_d.regs[`REG_VOLUME] = `RST_VOLUME;
            for (int i = 1; i < 5; i++) begin
                s_d.regs[i] = `RST_ATT;
            end
            s_d.regs[`REG_BASS] = `RST_BASS;
            s_d.regs[`REG_TREBLE] = `RST_TREBLE;
            s_d.regs[`REG_SWITCH] = `RST_SWITCH; // see (RULE21)
            s_d.phase = PH_IDLE; // see (RULE21)
            s_d.scl = 3'h7;
            s_d.sda = 3'h7;
            s_d.muteS = 2'h3;
            s_d.swL = 1'b1;
            s_d.swR = 1'b1;
            s_d.srcSelect = 5'h01;
            s_d.outMute = 4'hF;
            s_d.bassStep = toneMap(5'(`RST_BASS), `BASS_MID, `BASS_MAX);
            s_d.trebleStep = toneMap(5'(`RST_TREBLE), `TREB_MID, `TREB_MAX);
            s_d.eqPinsExternal = 1'b1;
        end
    end
    always_ff @(posedge core_clk) begin
        s_q <= s_d;
    end
    //--------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    // Open-drain: only ever pulls low
    assign sdaDrive = 1'b0;
    assign sdaOe = s_q.sdaOe;
    assign srcSelect = s_q.srcSelect;
    assign vol1Code = s_q.vol1Code;
    assign loudnessDepth = s_q.loudnessDepth;
    assign outAtten = s_q.outAtten;
    assign outMute = s_q.outMute;
    assign bassStep = s_q.bassStep;
    assign trebleStep = s_q.trebleStep;
    assign toneEnable = s_q.toneEnable;
    assign eqSendEnable = s_q.eqPinsExternal;
    assign eqReturnEnable = s_q.eqPinsExternal;
    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence s_zcArm;
        swWr && swZcm;
    endsequence
    sequence s_leftCross;
        s_q.pendL && zcEdgeL && !swWr;
    endsequence
    a_src_onehot: assert property ($onehot(srcSelect)) // see (RULE1)
        else $error("source select not one-hot");

    a_loud_flat: assert property ( // see (RULE5)
        s_q.regs[`REG_VOLUME][`VOL_LOUD_BIT] && s_q.regs[`REG_VOLUME][5:0] == 6'h00
        |=> loudnessDepth == 6'h00)
        else $error("loudness not flat at top volume");

    a_loud_limit: assert property ( // see (RULE5)
        s_q.regs[`REG_VOLUME][`VOL_LOUD_BIT] && s_q.regs[`REG_VOLUME][5:0] >= `LOUD_MAX_DEPTH
        |=> loudnessDepth == `LOUD_MAX_DEPTH)
        else $error("loudness depth not held at maximum");

    a_step_mute: assert property ( // see (RULE11)
        s_q.regs[`REG_ATT_FR][5:0] > `ATT_MAX_STEP |=> outMute[0])
        else $error("attenuator mute step did not mute");

    a_fast_mute: assert property ( // see (RULE13)
        swWr && !swZcm |=> s_q.swL == $past(swGmu) && s_q.swR == $past(swGmu) && !s_q.pendL)
        else $error("fast mute not applied at once");

    a_zc_wait: assert property ( // see (RULE14)
        s_zcArm ##1 (!zcEdgeL && !expire && !swWr) |=> s_q.pendL)
        else $error("left switch moved without crossing");

    a_left_cross: assert property ( // see (RULE15)
        s_leftCross |=> !s_q.pendL && s_q.swL == $past(curGmu))
        else $error("left crossing did not move switch");

    a_right_indep: assert property ( // see (RULE15)
        s_q.pendR && !zcEdgeR && !expire && !swWr |=> s_q.pendR)
        else $error("right switch moved without own crossing");

    a_zc_timeout: assert property ( // see (RULE16)
        expire && !swWr |=> !s_q.pendL && !s_q.pendR)
        else $error("timeout did not release pending switches");

    a_tmr_restart: assert property ( // see (RULE17)
        s_zcArm |=> s_q.pendL && s_q.pendR && s_q.tmr == TmrLoad)
        else $error("switch write did not restart timeout");

    a_hw_mute: assert property (!s_q.muteS[1] |=> outMute == 4'hF) // see (RULE18)
        else $error("mute pin did not mute all outputs");

    a_hw_release: assert property ( // see (RULE19)
        s_q.muteS[1] && !s_q.swL && !s_q.swR && s_q.regs[1][5:0] <= `ATT_MAX_STEP |=> !outMute[0])
        else $error("mute held after pin release");

    a_addr_nack: assert property ( // see (RULE22)
        addrDone && s_q.shift != `DEV_ADDR |=> !sdaOe && s_q.phase == PH_IDLE)
        else $error("foreign address acknowledged");

    a_sub_incr: assert property ( // see (RULE23)
        i2cDataDone |=> s_q.sub == 3'($past(s_q.sub) + 3'h1) && sdaOe)
        else $error("register select did not advance");

    a_reset_mute: assert property (@(posedge core_clk) disable iff (1'b0) // see (RULE21)
        rst |=> curGmu && s_q.phase == PH_IDLE && outMute == 4'hF)
        else $error("reset did not force mute");

    a_apb_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");

endmodule

// ===== dv/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model #(
    parameter int Half = 6
) (
    // Clock
    input wire logic core_clk,
    // Bus lines
    output logic scl,
    output logic sdaLow,
    input wire logic sdaLine
);
    // ----------------------------------------
    // Write-only bus master, SCL stands high between frames
    // ----------------------------------------
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic tick();
        repeat (Half) @(posedge core_clk);
    endtask
    task automatic start();
        sdaLow <= 1'b1;
        tick();
        scl <= 1'b0;
        tick();
    endtask
    // SDA moves only a full tick after SCL falls, so no false START or STOP
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sdaLow <= ~b[i];
            tick();
            scl <= 1'b1;
            tick();
            scl <= 1'b0;
            tick();
        end
        sdaLow <= 1'b0;
        tick();
        scl <= 1'b1;
        tick();
        ack = ~sdaLine;
        scl <= 1'b0;
        tick();
    endtask
    task automatic stop();
        sdaLow <= 1'b1;
        tick();
        scl <= 1'b1;
        tick();
        sdaLow <= 1'b0;
        tick();
    endtask
endmodule

// ===== dv/audio_gain_mute_control_tb.sv
`timescale 1ns/1ps
module audio_gain_mute_control_tb;
    import fader_pkg::*;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic sdaDrive, sdaOe, scl, sdaLow, sdaLine, muteN, zeroCrossL, zeroCrossR;
    logic [4:0] srcSelect;
    logic [5:0] vol1Code, loudnessDepth;
    logic [3:0][5:0] outAtten;
    logic [3:0] outMute;
    toneStep_t bassStep, trebleStep;
    logic toneEnable, eqSendEnable, eqReturnEnable;
    int n_mismatch = 0;
    int tests_run = 0;
    // Released SDA floats high through the pull-up
    assign sdaLine = ~(sdaLow | sdaOe);
    audio_gain_mute_control #(.ZcTimeoutCycles(50)) dut (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sclLine(scl), .sdaLine(sdaLine), .sdaDrive(sdaDrive), .sdaOe(sdaOe), .muteN(muteN),
        .zeroCrossL(zeroCrossL), .zeroCrossR(zeroCrossR), .srcSelect(srcSelect), .vol1Code(vol1Code),
        .loudnessDepth(loudnessDepth), .outAtten(outAtten), .outMute(outMute), .bassStep(bassStep),
        .trebleStep(trebleStep), .toneEnable(toneEnable), .eqSendEnable(eqSendEnable),
        .eqReturnEnable(eqReturnEnable));
    i2c_host_model host (.core_clk(core_clk), .scl(scl), .sdaLow(sdaLow), .sdaLine(sdaLine));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic waitC(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // One idle cycle after each transfer keeps psel from being driven twice in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        chk(32'(n < 20), 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, 32'h0);
    endtask
    function automatic logic [31:0] tone(input int c, input int mid);
        int d;
        d = c - mid;
        return {26'h0, 4'(d / 2), 1'(d > 0 && d % 2 != 0), 1'(d < 0 && d % 2 != 0)};
    endfunction
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic testReset();
        logic [31:0] r;
        logic e;
        chk({28'h0, outMute}, 32'hF);
        apb(1'b0, 8'h1C, 32'h0, r, e);
        chk(r, 32'h80);
        chk({27'h0, srcSelect}, 32'h1);
        apb(1'b0, 8'h24, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        apb(1'b1, 8'h20, 32'h1, r, e);
        chk({31'h0, e}, 32'h1);
    endtask
    task automatic testVolume();
        for (int c = 0; c <= 51; c++) begin
            wr(8'h00, 32'(c) | 32'h40);
            waitC(2);
            chk({26'h0, vol1Code}, 32'(c));
            chk({26'h0, loudnessDepth}, (c > 32) ? 32'd32 : 32'(c));
        end
        wr(8'h00, 32'h3F);
        waitC(2);
        chk({26'h0, vol1Code}, 32'h33);
        chk({26'h0, loudnessDepth}, 32'h0);
    endtask
    task automatic testSource();
        for (int s = 0; s < 8; s++) begin
            wr(8'h1C, 32'h08 | 32'(s));
            waitC(2);
            chk({27'h0, srcSelect}, (s < 4) ? (32'h1 << s) : 32'h10);
        end
        wr(8'h1C, 32'h00);
        waitC(2);
        chk({29'h0, toneEnable, eqSendEnable, eqReturnEnable}, 32'h3);
        wr(8'h1C, 32'h08);
        waitC(2);
        chk({29'h0, toneEnable, eqSendEnable, eqReturnEnable}, 32'h4);
    endtask
    task automatic testTone();
        for (int c = 0; c <= 20; c++) begin
            wr(8'h14, 32'(c));
            if (c <= 16) wr(8'h18, 32'(c));
            waitC(2);
            chk({26'h0, bassStep}, tone(c, 10));
            if (c <= 16) chk({26'h0, trebleStep}, tone(c, 8));
        end
    endtask
    task automatic testAtten();
        for (int i = 0; i < 4; i++) wr(8'(4 + 4 * i), 32'(10 + i));
        waitC(3);
        for (int i = 0; i < 4; i++) chk({26'h0, outAtten[i]}, 32'(10 + i));
        wr(8'h08, 32'd55);
        waitC(3);
        chk({28'h0, outMute}, 32'h0);
        wr(8'h08, 32'd56);
        waitC(3);
        chk({28'h0, outMute}, 32'h2);
        wr(8'h08, 32'd0);
    endtask
    task automatic testFastMute();
        wr(8'h1C, 32'h88);
        waitC(3);
        chk({28'h0, outMute}, 32'hF);
        wr(8'h1C, 32'h08);
        waitC(3);
        chk({28'h0, outMute}, 32'h0);
        muteN <= 1'b0;
        waitC(6);
        chk({28'h0, outMute}, 32'hF);
        muteN <= 1'b1;
        waitC(6);
        chk({28'h0, outMute}, 32'h0);
    endtask
    task automatic testZeroCross();
        wr(8'h1C, 32'hC8);
        waitC(6);
        chk({28'h0, outMute}, 32'h0);
        zeroCrossL <= ~zeroCrossL;
        waitC(6);
        chk({28'h0, outMute}, 32'hA);
        zeroCrossR <= ~zeroCrossR;
        waitC(6);
        chk({28'h0, outMute}, 32'hF);
        wr(8'h1C, 32'h48);
        waitC(30);
        wr(8'h1C, 32'h48);
        waitC(30);
        chk({28'h0, outMute}, 32'hF);
        waitC(35);
        chk({28'h0, outMute}, 32'h0);
        wr(8'h1C, 32'h08);
    endtask
    task automatic testSerial();
        logic a;
        host.start();
        host.send(8'h80, a);
        chk({31'h0, a}, 32'h1);
        host.send(8'h01, a);
        host.send(8'h21, a);
        host.send(8'h22, a);
        chk({31'h0, a}, 32'h1);
        host.stop();
        chk({20'h0, outAtten[1], outAtten[0]}, 32'h08A1);
        chk({31'h0, sdaDrive}, 32'h0);
        host.start();
        host.send(8'h82, a);
        chk({31'h0, a}, 32'h0);
        host.send(8'h01, a);
        host.send(8'h05, a);
        host.stop();
        chk({26'h0, outAtten[0]}, 32'h21);
    endtask
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        muteN = 1'b1;
        zeroCrossL = 1'b0;
        zeroCrossR = 1'b0;
        waitC(12);
        rst <= 1'b0;
        waitC(1);
        testReset();
        testVolume();
        testSource();
        testTone();
        testAtten();
        testFastMute();
        testZeroCross();
        testSerial();
        wr(8'h1C, 32'h88);
        print_verdict();
    end
    initial begin
        waitC(40000);
        n_mismatch++;
        print_verdict();
    end
endmodule
